// >>> rtl/dtc_pkg.sv
// Constants shared by the dual timer/counter pair.
// Assumes a single APB clock domain and 32-bit APB data.
package dtc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TCTRL = 8'h88;
  localparam logic [7:0] IDX_TMODE = 8'h89;
  localparam logic [7:0] IDX_T0_LO = 8'h8a;
  localparam logic [7:0] IDX_T1_LO = 8'h8b;
  localparam logic [7:0] IDX_T0_HI = 8'h8c;
  localparam logic [7:0] IDX_T1_HI = 8'h8d;
  localparam int ADDR_W = 12;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;

  // timer_control bit positions
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  localparam int TC_IE1 = 3;
  localparam int TC_IT1 = 2;
  localparam int TC_IE0 = 1;
  localparam int TC_IT0 = 0;

  // timer_mode_config bit positions
  localparam int TM_SECOND_GATE_CONTROL = 7;
  localparam int TM_CT1 = 6;
  localparam int TM_SECOND_MODE_FIELD_HI = 5;
  localparam int TM_SECOND_MODE_FIELD_LO = 4;
  localparam int TM_FIRST_GATE_CONTROL = 3;
  localparam int TM_CT0 = 2;
  localparam int TM_FIRST_MODE_FIELD_HI = 1;
  localparam int TM_FIRST_MODE_FIELD_LO = 0;

  // Internal timing rate: last prescaler count, giving one count per twelve clocks
  localparam logic [3:0] PRESCALE_LAST = 4'hb;

  // Flag vector order: tf1, tf0, ie1, ie0
  localparam int FL_TF1 = 3;
  localparam int FL_TF0 = 2;
  localparam int FL_IE1 = 1;
  localparam int FL_IE0 = 0;

  // Timer modes
  typedef enum logic [1:0] {
    DTC_M13 = 2'b00,
    DTC_M16 = 2'b01,
    DTC_RELOAD = 2'b10,
    DTC_SPLIT = 2'b11
  } dtc_mode_e;

endpackage

// >>> rtl/dtc_cnt_if.sv
// Link between the register/control logic and one timer core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dtc_cnt_if;
  dtc_pkg::dtc_mode_e mode;
  logic lo_inc;
  logic hi_inc;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [7:0] tl;
  logic [7:0] th;
  logic ovf_lo;
  logic ovf_hi;
  modport ctrl (output mode, lo_inc, hi_inc, wr_lo, wr_hi, wdata, input tl, th, ovf_lo, ovf_hi);
  modport core (input mode, lo_inc, hi_inc, wr_lo, wr_hi, wdata, output tl, th, ovf_lo, ovf_hi);
endinterface
`default_nettype wire

// >>> rtl/dtc_timer_core.sv
// One timer: low and high count bytes with 13, 16, reload and split modes.
// Assumes increments arrive already gated by run, gate and source select.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_core (
  input wire logic pclk,
  input wire logic presetn,
  dtc_cnt_if.core cif
);
  logic [7:0] tl;
  logic [7:0] th;
  logic [12:0] c13;
  logic [15:0] c16;
  logic [7:0] tl_inc;
  logic [7:0] th_inc;

  // Incremented views of the count
  assign c13 = {th, tl[4:0]} + 13'h0001;
  assign c16 = {th, tl} + 16'h0001;
  assign tl_inc = tl + 8'h01;
  assign th_inc = th + 8'h01;
  assign cif.tl = tl;
  assign cif.th = th;

  // Low byte; a software write wins over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tl <= dtc_pkg::RST_BYTE;
    end else if (cif.wr_lo) begin
      tl <= cif.wdata;
    end else if (cif.lo_inc) begin
      case (cif.mode)
        dtc_pkg::DTC_M13: tl[4:0] <= c13[4:0]; // see RQ1
        dtc_pkg::DTC_M16: tl <= c16[7:0]; // see RQ5
        dtc_pkg::DTC_RELOAD: tl <= (&tl) ? th : tl_inc; // see RQ6
        default: tl <= tl_inc;
      endcase
    end
  end

  // High byte; reload mode leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      th <= dtc_pkg::RST_BYTE;
    end else if (cif.wr_hi) begin
      th <= cif.wdata;
    end else begin
      case (cif.mode)
        dtc_pkg::DTC_M13: if (cif.lo_inc) th <= c13[12:5]; // see RQ1
        dtc_pkg::DTC_M16: if (cif.lo_inc) th <= c16[15:8]; // see RQ5
        dtc_pkg::DTC_SPLIT: if (cif.hi_inc) th <= th_inc; // see RQ24
        default: th <= th;
      endcase
    end
  end

  // Wrap detection from all ones to zero
  always_comb begin
    case (cif.mode)
      dtc_pkg::DTC_M13: cif.ovf_lo = cif.lo_inc & (&{th, tl[4:0]});
      dtc_pkg::DTC_M16: cif.ovf_lo = cif.lo_inc & (&{th, tl});
      default: cif.ovf_lo = cif.lo_inc & (&tl);
    endcase
    cif.ovf_hi = cif.hi_inc & (cif.mode == dtc_pkg::DTC_SPLIT) & (&th);
  end

  a_wrap_13bit: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.mode == dtc_pkg::DTC_M13 && cif.lo_inc && !cif.wr_lo && !cif.wr_hi && (&{th, tl[4:0]}))
    |=> (th == 8'h00 && tl[4:0] == 5'h00)) // see RQ1
    else $error("13-bit count did not wrap to zero");

endmodule
`default_nettype wire

// >>> rtl/dtc_top.sv
// Dual timer/counter pair with shared control and mode registers on APB.
// Assumes pins are asynchronous to pclk and an interrupt controller acks flags.
// Operation
// RQ1: Mode 0 counts 13 bits: high byte and low five bits of low byte.
// RQ2: Second timer wrap from all ones to zero sets its overflow flag.
// RQ3: Second timer advances only with run set and gate off or gate input high.
// RQ4: Setting the second run bit does not clear the count bytes.
// RQ5: Mode 1 is like mode 0 but uses all sixteen bits.
// RQ6: Mode 2 counts low byte, reloads it from high byte on overflow.
// RQ7: Second timer in mode 3 holds its count, as if stopped.
// RQ8: Second overflow flag at control bit 7, set on overflow, cleared on service.
// RQ9: First overflow flag at control bit 5, set on overflow, cleared on service.
// RQ10: Control bit 6 runs the second timer; cleared stops it.
// RQ11: Control bit 4 runs the first timer; cleared stops it.
// RQ12: Control bit 3 flags second external interrupt, cleared on service.
// RQ13: Control bit 1 flags first external interrupt, cleared on service.
// RQ14: Control bit 2 picks second interrupt trigger: 1 falling edge, 0 low.
// RQ15: Control bit 0 picks first interrupt trigger: 1 falling edge, 0 low.
// RQ16: Mode register gate bits: second at bit 7, first at bit 3.
// RQ17: Select bits 6 and 2 choose external counting when 1, timing when 0.
// RQ18: Second mode field 5:4 selects 13-bit, 16-bit, reload or halt.
// RQ19: First mode field 1:0 selects 13-bit, 16-bit, reload or split.
// RQ20: First timer count bytes are readable, writable, reset to zero.
// RQ21: Second timer count bytes are readable, writable, reset to zero.
// RQ22: Internal timing increments once every twelve clocks.
// RQ23: Counter mode increments on falling edges of the sampled count pin.
// RQ24: In split mode first high byte times, using second run bit and flag.
// RQ25: In split mode first low byte uses the first timer's own controls.
// RQ26: First timer in modes 0 to 2 behaves like the second.
// RQ27: Edge trigger sets flag on a sampled fall; level mode follows low input.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_count_pin,
  input wire logic second_count_pin,
  input wire logic first_gate_input,
  input wire logic second_gate_input,
  input wire logic first_ext_irq_pin,
  input wire logic second_ext_irq_pin,
  input wire logic [3:0] service_ack,
  output logic first_overflow_flag,
  output logic second_overflow_flag,
  output logic first_ext_irq_flag,
  output logic second_ext_irq_flag
);

  // Address decode, used for reads and writes
  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  // Pin synchroniser stages: {irq1, irq0, second_gate_input, first_gate_input, cnt1, cnt0}
  logic [5:0] pin_raw;
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [5:0] pin_prev;
  logic [5:0] pin_fall;

  // Register state
  logic [7:0] tmode;
  logic first_run_bit;
  logic second_run_bit;
  logic first_ext_irq_type;
  logic second_ext_irq_type;
  logic [3:0] flags;
  logic [3:0] presc;
  logic tick;

  // Decoded controls
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] tctrl_rd;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic first_gate_control;
  logic second_gate_control;
  logic first_counter_select;
  logic second_counter_select;
  dtc_pkg::dtc_mode_e first_mode_field;
  dtc_pkg::dtc_mode_e second_mode_field;
  logic split;
  logic run0;
  logic run1;
  logic src0;
  logic src1;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [3:0] next_flags;
  logic wr_t1;
  logic [15:0] t0_cnt;
  logic [15:0] t1_cnt;

  dtc_cnt_if t0_if ();
  dtc_cnt_if t1_if ();

  // Two flops per pin before any use
  assign pin_raw = {second_ext_irq_pin, first_ext_irq_pin, second_gate_input,
                    first_gate_input, second_count_pin, first_count_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 6'h3f;
      pin_sync <= 6'h3f;
      pin_prev <= 6'h3f;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Falling transitions seen at the clock rate
  assign pin_fall = pin_prev & ~pin_sync; // see RQ23

  // Divide by twelve for internal timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= dtc_pkg::RST_NIB;
    end else if (presc == dtc_pkg::PRESCALE_LAST) begin
      presc <= dtc_pkg::RST_NIB; // see RQ22
    end else begin
      presc <= presc + 4'h1;
    end
  end
  assign tick = (presc == dtc_pkg::PRESCALE_LAST);

  // APB access phase commits a write
  assign wr_en = psel & penable & pready & pwrite;
  assign wbyte = pwdata[7:0];

  // Mode register fields
  assign second_gate_control = tmode[dtc_pkg::TM_SECOND_GATE_CONTROL]; // see RQ16
  assign first_gate_control = tmode[dtc_pkg::TM_FIRST_GATE_CONTROL]; // see RQ16
  assign second_counter_select = tmode[dtc_pkg::TM_CT1]; // see RQ17
  assign first_counter_select = tmode[dtc_pkg::TM_CT0]; // see RQ17
  assign second_mode_field = dtc_pkg::dtc_mode_e'(tmode[dtc_pkg::TM_SECOND_MODE_FIELD_HI:dtc_pkg::TM_SECOND_MODE_FIELD_LO]); // see RQ18
  assign first_mode_field = dtc_pkg::dtc_mode_e'(tmode[dtc_pkg::TM_FIRST_MODE_FIELD_HI:dtc_pkg::TM_FIRST_MODE_FIELD_LO]); // see RQ19
  assign split = (first_mode_field == dtc_pkg::DTC_SPLIT);

  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmode <= dtc_pkg::RST_BYTE;
    end else if (wr_en && reg_hit(paddr, dtc_pkg::IDX_TMODE)) begin
      tmode <= wbyte;
    end
  end

  // Run and trigger type bits of the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_run_bit <= 1'b0;
      second_run_bit <= 1'b0;
      first_ext_irq_type <= 1'b0;
      second_ext_irq_type <= 1'b0;
    end else if (wr_en && reg_hit(paddr, dtc_pkg::IDX_TCTRL)) begin
      second_run_bit <= wbyte[dtc_pkg::TC_TR1]; // see RQ10
      first_run_bit <= wbyte[dtc_pkg::TC_TR0]; // see RQ11
      second_ext_irq_type <= wbyte[dtc_pkg::TC_IT1]; // see RQ14
      first_ext_irq_type <= wbyte[dtc_pkg::TC_IT0]; // see RQ15
    end
  end

  // Counting enables: run, gate and count source
  assign run0 = first_run_bit & (~first_gate_control | pin_sync[2]); // see RQ11
  assign run1 = second_run_bit & (~second_gate_control | pin_sync[3]); // see RQ3
  assign src0 = first_counter_select ? pin_fall[0] : tick; // see RQ17
  assign src1 = second_counter_select ? pin_fall[1] : tick; // see RQ17

  // First timer: own controls for low byte, split high byte on second run
  assign t0_if.mode = first_mode_field; // see RQ26
  assign t0_if.lo_inc = run0 & src0; // see RQ25
  assign t0_if.hi_inc = split & second_run_bit & tick; // see RQ24
  assign t0_if.wr_lo = wr_en & reg_hit(paddr, dtc_pkg::IDX_T0_LO); // see RQ20
  assign t0_if.wr_hi = wr_en & reg_hit(paddr, dtc_pkg::IDX_T0_HI); // see RQ20
  assign t0_if.wdata = wbyte;

  // Second timer: mode 3 means no increments at all
  assign t1_if.mode = second_mode_field;
  assign t1_if.lo_inc = (second_mode_field != dtc_pkg::DTC_SPLIT) & run1 & src1; // see RQ7
  assign t1_if.hi_inc = 1'b0;
  assign t1_if.wr_lo = wr_en & reg_hit(paddr, dtc_pkg::IDX_T1_LO); // see RQ21
  assign t1_if.wr_hi = wr_en & reg_hit(paddr, dtc_pkg::IDX_T1_HI); // see RQ21
  assign t1_if.wdata = wbyte;
  assign wr_t1 = t1_if.wr_lo | t1_if.wr_hi;

  // Timer cores; run bit writes never touch the counts
  dtc_timer_core u_t0 (
    .pclk(pclk),
    .presetn(presetn),
    .cif(t0_if.core)
  );

  dtc_timer_core u_t1 ( // see RQ4
    .pclk(pclk),
    .presetn(presetn),
    .cif(t1_if.core)
  );

  // Flag sources; split mode hands the second flag to the first high byte
  assign flag_set[dtc_pkg::FL_TF1] = split ? t0_if.ovf_hi : t1_if.ovf_lo; // see RQ2
  assign flag_set[dtc_pkg::FL_TF0] = t0_if.ovf_lo; // see RQ9
  assign flag_set[dtc_pkg::FL_IE1] = second_ext_irq_type & pin_fall[5]; // see RQ12
  assign flag_set[dtc_pkg::FL_IE0] = first_ext_irq_type & pin_fall[4]; // see RQ13

  // Clears: service acknowledge or a software write of zero
  always_comb begin
    flag_clr = service_ack;
    if (wr_en && reg_hit(paddr, dtc_pkg::IDX_TCTRL)) begin
      flag_clr = flag_clr | ~{wbyte[dtc_pkg::TC_TF1], wbyte[dtc_pkg::TC_TF0],
                              wbyte[dtc_pkg::TC_IE1], wbyte[dtc_pkg::TC_IE0]};
    end
  end

  // Next flags: set beats clear, level mode follows the pin
  always_comb begin
    next_flags = (flags & ~flag_clr) | flag_set; // see RQ8
    if (wr_en && reg_hit(paddr, dtc_pkg::IDX_TCTRL)) begin
      next_flags = next_flags | {wbyte[dtc_pkg::TC_TF1], wbyte[dtc_pkg::TC_TF0],
                                 wbyte[dtc_pkg::TC_IE1], wbyte[dtc_pkg::TC_IE0]};
    end
    if (!second_ext_irq_type) begin
      next_flags[dtc_pkg::FL_IE1] = ~pin_sync[5]; // see RQ27
    end
    if (!first_ext_irq_type) begin
      next_flags[dtc_pkg::FL_IE0] = ~pin_sync[4]; // see RQ27
    end
  end

  // Flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= dtc_pkg::RST_NIB;
    end else begin
      flags <= next_flags;
    end
  end

  // Flag outputs straight from the flag flops
  assign second_overflow_flag = flags[dtc_pkg::FL_TF1];
  assign first_overflow_flag = flags[dtc_pkg::FL_TF0];
  assign second_ext_irq_flag = flags[dtc_pkg::FL_IE1];
  assign first_ext_irq_flag = flags[dtc_pkg::FL_IE0];

  // Control register read view
  always_comb begin
    tctrl_rd = dtc_pkg::RST_BYTE;
    tctrl_rd[dtc_pkg::TC_TF1] = flags[dtc_pkg::FL_TF1];
    tctrl_rd[dtc_pkg::TC_TR1] = second_run_bit;
    tctrl_rd[dtc_pkg::TC_TF0] = flags[dtc_pkg::FL_TF0];
    tctrl_rd[dtc_pkg::TC_TR0] = first_run_bit;
    tctrl_rd[dtc_pkg::TC_IE1] = flags[dtc_pkg::FL_IE1];
    tctrl_rd[dtc_pkg::TC_IT1] = second_ext_irq_type;
    tctrl_rd[dtc_pkg::TC_IE0] = flags[dtc_pkg::FL_IE0];
    tctrl_rd[dtc_pkg::TC_IT0] = first_ext_irq_type;
  end

  // Read mux with unmapped detection
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = dtc_pkg::RST_BYTE;
    if (reg_hit(paddr, dtc_pkg::IDX_TCTRL)) begin
      rd_byte = tctrl_rd;
    end else if (reg_hit(paddr, dtc_pkg::IDX_TMODE)) begin
      rd_byte = tmode;
    end else if (reg_hit(paddr, dtc_pkg::IDX_T0_LO)) begin
      rd_byte = t0_if.tl;
    end else if (reg_hit(paddr, dtc_pkg::IDX_T1_LO)) begin
      rd_byte = t1_if.tl;
    end else if (reg_hit(paddr, dtc_pkg::IDX_T0_HI)) begin
      rd_byte = t0_if.th;
    end else if (reg_hit(paddr, dtc_pkg::IDX_T1_HI)) begin
      rd_byte = t1_if.th;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // APB answer: one wait-free access, data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Helper views of the full counts
  assign t0_cnt = {t0_if.th, t0_if.tl};
  assign t1_cnt = {t1_if.th, t1_if.tl};

  default clocking dtc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_tick_gap;
    (!tick) [*8] ##1 (!tick) [*3] ##1 tick;
  endsequence

  a_prescale_period: assert property (tick |=> s_tick_gap) // see RQ22
    else $error("internal tick not every twelve clocks");

  a_second_halt: assert property ((second_mode_field == dtc_pkg::DTC_SPLIT) && !wr_t1
    |=> $stable(t1_cnt)) // see RQ7
    else $error("second timer moved in halt mode");

  a_second_stopped: assert property (!second_run_bit && !wr_t1
    |=> $stable(t1_cnt)) // see RQ10
    else $error("second timer moved with run clear");

  a_second_gate: assert property (second_gate_control && !pin_sync[3] && !wr_t1
    |=> $stable(t1_cnt)) // see RQ3
    else $error("second timer moved with gate low");

  a_second_ovf_flag: assert property (t1_if.ovf_lo && !split
    |=> second_overflow_flag) // see RQ2
    else $error("second overflow flag not set");

  a_reload_low: assert property (second_mode_field == dtc_pkg::DTC_RELOAD && t1_if.lo_inc
    && (&t1_if.tl) && !wr_t1 |=> (t1_if.tl == $past(t1_if.th)) && $stable(t1_if.th)) // see RQ6
    else $error("low byte not reloaded from high byte");

  a_edge_irq: assert property (first_ext_irq_type && pin_fall[4]
    |=> first_ext_irq_flag) // see RQ27
    else $error("falling edge did not set first irq flag");

  a_level_irq: assert property (!second_ext_irq_type
    |=> second_ext_irq_flag == !$past(pin_sync[5])) // see RQ14
    else $error("level irq flag does not follow pin");

  a_count_fall: assert property (first_counter_select && run0 && pin_fall[0]
    && first_mode_field == dtc_pkg::DTC_M16 && !t0_if.wr_lo && !t0_if.wr_hi
    |=> t0_cnt == 16'($past(t0_cnt) + 16'h0001)) // see RQ23
    else $error("count pin fall did not advance first timer");

  a_split_high: assert property (split && second_run_bit && tick && !t0_if.wr_hi
    && !(&t0_if.th) |=> t0_if.th == 8'($past(t0_if.th) + 8'h01)) // see RQ24
    else $error("split high byte did not advance");

  a_first_ovf_flag: assert property (t0_if.ovf_lo |=> first_overflow_flag) // see RQ9
    else $error("first overflow flag not set");

endmodule
`default_nettype wire

// >>> verification/dtc_pins_model.sv
// Model of the external count, gate and interrupt pins of the timer pair.
// Assumes pins change just after a rising pclk edge and idle high where pulled up.
`timescale 1ns/1ps
`default_nettype none
module dtc_pins_model (
  input wire logic pclk,
  output logic first_count_pin,
  output logic second_count_pin,
  output logic first_gate_input,
  output logic second_gate_input,
  output logic first_ext_irq_pin,
  output logic second_ext_irq_pin
);
  // Idle levels: count and interrupt pins pulled high, gates closed
  initial begin
    first_count_pin = 1'b1;
    second_count_pin = 1'b1;
    first_gate_input = 1'b0;
    second_gate_input = 1'b0;
    first_ext_irq_pin = 1'b1;
    second_ext_irq_pin = 1'b1;
  end
  // Falling transitions, each level held well past the sampling delay
  task automatic count_pulses(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      if (sel == 0) first_count_pin <= 1'b0;
      else second_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      if (sel == 0) first_count_pin <= 1'b1;
      else second_count_pin <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask
  // Gate level for one timer
  task automatic set_gate(input int sel, input logic v);
    @(posedge pclk);
    if (sel == 0) first_gate_input <= v;
    else second_gate_input <= v;
  endtask
  // Interrupt pin level, active low
  task automatic set_irq(input int sel, input logic v);
    @(posedge pclk);
    if (sel == 0) first_ext_irq_pin <= v;
    else second_ext_irq_pin <= v;
  endtask
endmodule
`default_nettype wire

// >>> verification/dual_timer_counter_pair_tb.sv
// Self-checking bench for the dual timer/counter pair over APB.
// Assumes dtc_pkg, dtc_top and dtc_pins_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_pair_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] service_ack;
  logic fo, so, fe, se;
  wire t0p, t1p, g0, g1, i0, i1;
  wire [3:0] fl;
  int error_cnt, n_compared;
  localparam logic [7:0] TC = dtc_pkg::IDX_TCTRL;
  localparam logic [7:0] TM = dtc_pkg::IDX_TMODE;
  localparam logic [7:0] L0 = dtc_pkg::IDX_T0_LO;
  localparam logic [7:0] L1 = dtc_pkg::IDX_T1_LO;
  localparam logic [7:0] H0 = dtc_pkg::IDX_T0_HI;
  localparam logic [7:0] H1 = dtc_pkg::IDX_T1_HI;
  // Flags in service_ack order
  assign fl = {so, fo, se, fe};
  dtc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_count_pin(t0p), .second_count_pin(t1p), .first_gate_input(g0), .second_gate_input(g1),
    .first_ext_irq_pin(i0), .second_ext_irq_pin(i1), .service_ack(service_ack),
    .first_overflow_flag(fo), .second_overflow_flag(so), .first_ext_irq_flag(fe), .second_ext_irq_flag(se));
  dtc_pins_model u_pins (.pclk(pclk), .first_count_pin(t0p), .second_count_pin(t1p), .first_gate_input(g0),
    .second_gate_input(g1), .first_ext_irq_pin(i0), .second_ext_irq_pin(i1));
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Value must lie within lo..hi
  task automatic chk_rng(input string nm, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] g);
    n_compared++;
    if (!(g >= lo && g <= hi) || $isunknown(g)) begin
      error_cnt++;
      $display("ERROR %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 20) begin
      error_cnt++;
      $display("ERROR pready timeout");
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, {2'b00, idx, 2'b00}, d, r, e);
  endtask
  task automatic rv(input logic [7:0] idx, output logic [7:0] v);
    logic [31:0] r;
    logic e;
    xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00, r, e);
    v = r[7:0];
  endtask
  task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] v;
    rv(idx, v);
    chk(nm, e, v);
  endtask
  // Bounded wait for a flag to reach a level
  task automatic wait_fl(input int b, input logic v);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge pclk);
      if (fl[b] === v) break;
    end
    chk("flag wait", {7'h0, v}, {7'h0, fl[b]});
    if (i == 400) tally_and_finish();
  endtask
  task automatic ack(input int b);
    @(posedge pclk);
    service_ack <= 4'(1 << b);
    @(posedge pclk);
    service_ack <= 4'h0;
  endtask
  // Reset values, read/write access and the refused address
  task automatic s_regs();
    logic [31:0] r;
    logic e;
    for (int k = 0; k < 6; k++) rc("reset value", TC + 8'(k), 8'h00);
    for (int k = 2; k < 6; k++) wr(TC + 8'(k), 8'ha5 ^ 8'(k));
    for (int k = 2; k < 6; k++) rc("byte readback", TC + 8'(k), 8'ha5 ^ 8'(k));
    wr(TM, 8'hb6);
    rc("mode readback", TM, 8'hb6);
    wr(TM, 8'h00);
    wr(TC, 8'h05);
    rc("control readback", TC, 8'h05);
    xfer(1'b0, 12'h004, 8'h00, r, e);
    chk("unmapped error", 8'h01, {7'h0, e});
    chk("unmapped data", 8'h00, r[7:0]);
  endtask
  // Internal rate: about 1203 clocks running gives 100 or 101 ticks
  task automatic s_rate();
    logic [7:0] v;
    wr(TM, 8'h10);
    wr(L1, 8'h00);
    wr(H1, 8'h00);
    wr(TC, 8'h40);
    repeat (1200) @(posedge pclk);
    wr(TC, 8'h00);
    rv(L1, v);
    chk_rng("tick count", 8'h64, 8'h65, v);
    repeat (60) @(posedge pclk);
    rc("stopped count", L1, v);
  endtask
  // Sixteen-bit wrap of the second timer and flag service
  task automatic s_m1();
    logic [7:0] v;
    wr(H1, 8'hff);
    wr(L1, 8'hfe);
    wr(TC, 8'h40);
    rv(L1, v);
    chk_rng("run keeps count", 8'hfe, 8'hff, v);
    wait_fl(3, 1'b1);
    wr(TC, 8'h80);
    rc("wrapped high", H1, 8'h00);
    rc("flag bit 7", TC, 8'h80);
    ack(3);
    wait_fl(3, 1'b0);
  endtask
  // Thirteen-bit wrap of the first timer from 0x1f low
  task automatic s_m0();
    wr(TM, 8'h00);
    wr(H0, 8'hff);
    wr(L0, 8'h1f);
    wr(TC, 8'h10);
    wait_fl(2, 1'b1);
    wr(TC, 8'h20);
    rc("13-bit high", H0, 8'h00);
    rc("13-bit low", L0, 8'h00);
    rc("flag bit 5", TC, 8'h20);
    ack(2);
    wait_fl(2, 1'b0);
  endtask
  // Auto-reload and halt mode of the second timer
  task automatic s_m2_m3();
    logic [7:0] v;
    wr(TM, 8'h20);
    wr(H1, 8'h80);
    wr(L1, 8'hff);
    wr(TC, 8'h40);
    wait_fl(3, 1'b1);
    wr(TC, 8'h80);
    rc("reload high", H1, 8'h80);
    rv(L1, v);
    chk_rng("reloaded low", 8'h80, 8'h81, v);
    ack(3);
    wr(TM, 8'h30);
    wr(L1, 8'h10);
    wr(TC, 8'h40);
    repeat (60) @(posedge pclk);
    rc("halted count", L1, 8'h10);
    wr(TC, 8'h00);
  endtask
  // Gate input holds the count until raised
  task automatic s_gate();
    logic [7:0] v;
    wr(TM, 8'h90);
    wr(L1, 8'h00);
    wr(TC, 8'h40);
    repeat (60) @(posedge pclk);
    rc("gated count", L1, 8'h00);
    u_pins.set_gate(1, 1'b1);
    repeat (60) @(posedge pclk);
    wr(TC, 8'h00);
    rv(L1, v);
    chk_rng("gate open count", 8'h04, 8'h06, v);
    u_pins.set_gate(1, 1'b0);
  endtask
  // External events on both count pins, second timer in 13-bit mode
  task automatic s_cnt();
    wr(TM, 8'h45);
    wr(L0, 8'h00);
    wr(L1, 8'h00);
    wr(TC, 8'h50);
    u_pins.count_pulses(0, 5);
    u_pins.count_pulses(1, 5);
    repeat (8) @(posedge pclk);
    wr(TC, 8'h00);
    rc("event count", L0, 8'h05);
    rc("second event count", L1, 8'h05);
  endtask
  // Split mode: first high byte drives the second overflow flag
  task automatic s_split();
    wr(TM, 8'h03);
    wr(H0, 8'hff);
    wr(L0, 8'h00);
    wr(TC, 8'h40);
    wait_fl(3, 1'b1);
    wr(TC, 8'h80);
    rc("split low idle", L0, 8'h00);
    chk("first flag idle", 8'h00, {7'h0, fo});
    ack(3);
  endtask
  // Edge then level trigger on both interrupt pins
  task automatic s_irq();
    wr(TC, 8'h05);
    for (int b = 0; b < 2; b++) begin
      u_pins.set_irq(b, 1'b0);
      wait_fl(b, 1'b1);
      u_pins.set_irq(b, 1'b1);
      repeat (10) @(posedge pclk);
      chk("edge flag held", 8'h01, {7'h0, fl[b]});
      ack(b);
      wait_fl(b, 1'b0);
    end
    wr(TC, 8'h00);
    for (int b = 0; b < 2; b++) begin
      u_pins.set_irq(b, 1'b0);
      wait_fl(b, 1'b1);
      u_pins.set_irq(b, 1'b1);
      wait_fl(b, 1'b0);
    end
  endtask
  // Reset, then the scenarios in turn
  initial begin
    error_cnt = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    service_ack = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_rate();
    s_m1();
    s_m0();
    s_m2_m3();
    s_gate();
    s_cnt();
    s_split();
    s_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
